// ### rtl/ctp_pkg.sv
// package: register map, field layouts and carriers of the compare-trigger and pwm block
package ctp_pkg;
  // bus, duty and counter widths, unit and flag counts
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int DUTY_W  = 10;
  localparam int TB2_W   = 8;
  localparam int TB1_W   = 16;
  localparam int PRESC_W = 6;
  localparam int N_UNIT  = 2;
  localparam int N_FLAG  = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_LOW  [N_UNIT] = '{8'h00, 8'h0C};
  localparam logic [ADDR_W-1:0] OFS_HIGH [N_UNIT] = '{8'h04, 8'h10};
  localparam logic [ADDR_W-1:0] OFS_CTRL [N_UNIT] = '{8'h08, 8'h14};
  localparam logic [ADDR_W-1:0] OFS_PERIOD    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_TB2_CTRL  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_TB2_COUNT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_TB1_COUNT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_TB1_CTRL  = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h2C;

  // writable bits of the 8-bit control registers
  localparam logic [7:0] CTRL_WMASK    = 8'h3F;
  localparam logic [7:0] TB2_CTRL_MASK = 8'h7F;

  // mode select codes
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  localparam logic [1:0] MODE_CMP_TOP = 2'h2;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // prescale select and terminal counts (4 clocks per step times the factor)
  localparam logic [1:0]         PS_DIV1    = 2'h0;
  localparam logic [1:0]         PS_DIV4    = 2'h1;
  localparam logic [PRESC_W-1:0] PRESC_LIM1 = 6'h03;
  localparam logic [PRESC_W-1:0] PRESC_LIM4 = 6'h0F;
  localparam logic [PRESC_W-1:0] PRESC_LIM16 = 6'h3F;

  // status flag positions
  localparam int ST_POST = 2;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] dc_lsb;
    logic [3:0] mode;
  } ctp_ctrl_s;

  typedef struct packed {
    logic       rsvd;
    logic [3:0] postscale;
    logic       on;
    logic [1:0] prescale;
  } ctp_tb2ctl_s;

  // pwm time base as seen by a unit
  typedef struct packed {
    logic              period_event;
    logic [DUTY_W-1:0] count_ext;
  } ctp_tb_s;

  // compare time base as seen by a unit
  typedef struct packed {
    logic             running;
    logic [TB1_W-1:0] count;
  } ctp_t1_s;
endpackage

// ### rtl/ctp_top.sv
// compare special event trigger and standard pwm, two units behind an axi4-lite slave
`timescale 1ns/1ps
module ctp_top (
  // clock, reset, enable
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           ce,
  // axi4-lite write address
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [ctp_pkg::ADDR_W-1:0]     s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [ctp_pkg::DATA_W-1:0]     s_axi_wdata,
  input  wire logic [ctp_pkg::DATA_W/8-1:0]   s_axi_wstrb,
  // axi4-lite write response
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic [1:0]                          s_axi_bresp,
  // axi4-lite read address
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [ctp_pkg::ADDR_W-1:0]     s_axi_araddr,
  // axi4-lite read data
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic [ctp_pkg::DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  // converter
  input  wire logic                           adc_enabled,
  output logic                                adc_start,
  // unit outputs
  output logic [ctp_pkg::N_UNIT-1:0]          unit_pin
);
  localparam int NU = ctp_pkg::N_UNIT;

  logic                             aw_held;
  logic                             w_held;
  logic [ctp_pkg::ADDR_W-1:0]       wr_addr;
  logic [ctp_pkg::DATA_W-1:0]       wr_data;
  logic [ctp_pkg::DATA_W/8-1:0]     wr_strb;
  logic                             wr_go;
  logic                             wr_hit;
  logic                             wr_b0;
  logic                             wr_b1;
  logic [ctp_pkg::DATA_W-1:0]       rd_word;
  logic                             rd_hit;

  logic [7:0]                       u_low  [NU];
  ctp_pkg::ctp_ctrl_s               u_ctrl [NU];
  logic [7:0]                       u_high [NU];
  logic [NU-1:0]                    u_match;
  logic [NU-1:0]                    u_special;
  logic [NU-1:0]                    u_pwm;

  logic [ctp_pkg::TB2_W-1:0]        period_reg;
  ctp_pkg::ctp_tb2ctl_s             tb2_ctl;
  logic [ctp_pkg::TB2_W-1:0]        tb2_count;
  logic [ctp_pkg::PRESC_W-1:0]      presc;
  logic [ctp_pkg::PRESC_W-1:0]      presc_lim;
  logic [ctp_pkg::PRESC_W-1:0]      next_presc;
  logic [ctp_pkg::TB2_W-1:0]        next_tb2_count;
  logic [1:0]                       ext;
  logic                             tick;
  logic                             period_event;
  logic [3:0]                       post_cnt;
  logic                             post_event;
  ctp_pkg::ctp_tb_s                 tb;

  logic [ctp_pkg::TB1_W-1:0]        tb1_count;
  logic                             tb1_on;
  ctp_pkg::ctp_t1_s                 t1;
  logic [ctp_pkg::N_FLAG-1:0]       flags;
  logic [ctp_pkg::N_FLAG-1:0]       flag_set;
  logic [ctp_pkg::N_FLAG-1:0]       flag_clr;

  // ---------------- axi4-lite write side
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_b0 = wr_go && wr_strb[0];
  assign wr_b1 = wr_go && wr_strb[1];
  assign wr_hit = wr_addr inside {ctp_pkg::OFS_LOW[0], ctp_pkg::OFS_HIGH[0], ctp_pkg::OFS_CTRL[0],
                                  ctp_pkg::OFS_LOW[1], ctp_pkg::OFS_HIGH[1], ctp_pkg::OFS_CTRL[1],
                                  ctp_pkg::OFS_PERIOD, ctp_pkg::OFS_TB2_CTRL, ctp_pkg::OFS_TB2_COUNT,
                                  ctp_pkg::OFS_TB1_COUNT, ctp_pkg::OFS_TB1_CTRL, ctp_pkg::OFS_STATUS};

  // address and data are held until both are in, then answered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      wr_addr      <= '0;
      wr_data      <= '0;
      wr_strb      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ctp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? ctp_pkg::RESP_OKAY : ctp_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- axi4-lite read side
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      ctp_pkg::OFS_LOW[0]:     rd_word[7:0] = u_low[0];
      ctp_pkg::OFS_HIGH[0]:    rd_word[7:0] = u_high[0];
      ctp_pkg::OFS_CTRL[0]:    rd_word[7:0] = u_ctrl[0];
      ctp_pkg::OFS_LOW[1]:     rd_word[7:0] = u_low[1];
      ctp_pkg::OFS_HIGH[1]:    rd_word[7:0] = u_high[1];
      ctp_pkg::OFS_CTRL[1]:    rd_word[7:0] = u_ctrl[1];
      ctp_pkg::OFS_PERIOD:     rd_word[7:0] = period_reg;
      ctp_pkg::OFS_TB2_CTRL:   rd_word[7:0] = tb2_ctl;
      ctp_pkg::OFS_TB2_COUNT:  rd_word[7:0] = tb2_count;
      ctp_pkg::OFS_TB1_COUNT:  rd_word[15:0] = tb1_count;
      ctp_pkg::OFS_TB1_CTRL:   rd_word[0] = tb1_on;
      ctp_pkg::OFS_STATUS:     rd_word[ctp_pkg::N_FLAG-1:0] = flags;
      default:                 rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ctp_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? ctp_pkg::RESP_OKAY : ctp_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- pwm time base
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_reg <= '0;
      tb2_ctl    <= '0;
    end else if (ce) begin
      if (wr_b0 && wr_addr == ctp_pkg::OFS_PERIOD) begin
        period_reg <= wr_data[7:0];
      end
      if (wr_b0 && wr_addr == ctp_pkg::OFS_TB2_CTRL) begin
        tb2_ctl <= ctp_pkg::ctp_tb2ctl_s'(wr_data[7:0] & ctp_pkg::TB2_CTRL_MASK);
      end
    end
  end

  always_comb begin
    unique case (tb2_ctl.prescale)
      ctp_pkg::PS_DIV1: presc_lim = ctp_pkg::PRESC_LIM1;
      ctp_pkg::PS_DIV4: presc_lim = ctp_pkg::PRESC_LIM4;
      default:          presc_lim = ctp_pkg::PRESC_LIM16;
    endcase
  end

  // top two bits of the next prescale state, for the selected factor, extend the base
  always_comb begin
    unique case (tb2_ctl.prescale)
      ctp_pkg::PS_DIV1: ext = next_presc[1:0];
      ctp_pkg::PS_DIV4: ext = next_presc[3:2];
      default:          ext = next_presc[5:4];
    endcase
  end

  // one step per 4 clocks times prescale
  assign tick = tb2_ctl.on && (presc == presc_lim);
  assign period_event = tick && (tb2_count == period_reg);
  assign next_presc = (!tb2_ctl.on || tick) ? '0 : presc + 1'b1;
  // base cleared on the step after match
  assign next_tb2_count = period_event ? '0 : (tick ? tb2_count + 1'b1 : tb2_count);
  // pin compare looks one clock ahead so the high time is exactly duty clocks times prescale
  assign tb = '{period_event: period_event, count_ext: {next_tb2_count, ext}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc <= '0;
    end else if (ce) begin
      presc <= next_presc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb2_count <= '0;
    end else if (ce) begin
      tb2_count <= next_tb2_count;
    end
  end

  // postscaler only paces the update flag
  assign post_event = period_event && (post_cnt == tb2_ctl.postscale);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      post_cnt <= '0;
    end else if (ce && period_event) begin
      post_cnt <= post_event ? '0 : post_cnt + 1'b1;
    end
  end

  // ---------------- compare time base
  assign t1 = '{running: tb1_on, count: tb1_count};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb1_on <= 1'b0;
    end else if (ce && wr_b0 && wr_addr == ctp_pkg::OFS_TB1_CTRL) begin
      tb1_on <= wr_data[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb1_count <= '0;
    end else if (ce) begin
      if (|u_special) begin
        tb1_count <= '0;
      end else if ((wr_b0 || wr_b1) && wr_addr == ctp_pkg::OFS_TB1_COUNT) begin
        tb1_count[7:0]  <= wr_b0 ? wr_data[7:0] : tb1_count[7:0];
        tb1_count[15:8] <= wr_b1 ? wr_data[15:8] : tb1_count[15:8];
      end else if (tb1_on) begin
        tb1_count <= tb1_count + 1'b1;
      end
    end
  end

  // ---------------- units
  for (genvar i = 0; i < NU; i++) begin : g_unit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        u_low[i]  <= '0;
        u_ctrl[i] <= '0;
      end else if (ce && wr_b0) begin
        if (wr_addr == ctp_pkg::OFS_LOW[i]) begin
          u_low[i] <= wr_data[7:0];
        end
        if (wr_addr == ctp_pkg::OFS_CTRL[i]) begin
          u_ctrl[i] <= ctp_pkg::ctp_ctrl_s'(wr_data[7:0] & ctp_pkg::CTRL_WMASK);
        end
      end
    end

    ctp_unit #(
      .DUTY_W (ctp_pkg::DUTY_W)
    ) u_unit (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .ctrl      (u_ctrl[i]),
      .duty_low  (u_low[i]),
      .wr_high   (wr_b0 && wr_addr == ctp_pkg::OFS_HIGH[i]),
      .wr_byte   (wr_data[7:0]),
      .tb        (tb),
      .t1        (t1),
      .pin       (unit_pin[i]),
      .match     (u_match[i]),
      .special   (u_special[i]),
      .pwm_mode  (u_pwm[i]),
      .data_high (u_high[i])
    );
  end

  // ---------------- request flags, write one to clear, set wins
  assign flag_set = {post_event, u_match};
  assign flag_clr = (wr_b0 && wr_addr == ctp_pkg::OFS_STATUS) ? wr_data[ctp_pkg::N_FLAG-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else if (ce) begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_start <= 1'b0;
    end else if (ce) begin
      adc_start <= u_special[1] && adc_enabled;
    end
  end

  // ---------------- checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pwm_wrap;
    ce && u_pwm[0] && period_event;
  endsequence
  sequence s_duty_nonzero;
    (u_low[0] != '0) || (u_ctrl[0].dc_lsb != '0);
  endsequence

  a_trigger_mode: assert property (u_special[1] |-> u_ctrl[1].mode == ctp_pkg::MODE_SPECIAL)
    else $error("trigger outside special mode");
  a_timer_reset: assert property (ce && |u_special |=> tb1_count == '0)
    else $error("compare timer not reset by trigger");
  a_adc_start: assert property (ce && u_special[1] && adc_enabled |=> adc_start ##1 (!ce || !adc_start))
    else $error("conversion start missing or stretched");
  a_off_low: assert property (ce && u_ctrl[1].mode == ctp_pkg::MODE_OFF |=> !unit_pin[1])
    else $error("output latch not low while off");
  a_period_clear: assert property (s_pwm_wrap |=> tb2_count == '0 && presc == '0)
    else $error("time base not cleared at period end");
  a_pin_set: assert property (s_pwm_wrap ##0 s_duty_nonzero |=> unit_pin[0])
    else $error("pin not set at period end");
  a_duty_latch: assert property (s_pwm_wrap |=> u_high[0] == $past(u_low[0]))
    else $error("duty not latched at period end");
  a_high_ro: assert property (ce && u_pwm[0] && !period_event |=> $stable(u_high[0]))
    else $error("high buffer changed mid period");
  a_flag_set: assert property (ce && u_match[0] |=> flags[0])
    else $error("request flag not set on match");
endmodule

// ### rtl/ctp_unit.sv
// one compare/pwm unit: duty double buffer, output latch and compare match
`timescale 1ns/1ps
module ctp_unit #(
  parameter int DUTY_W = ctp_pkg::DUTY_W
) (
  // clock, reset, enable
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // software registers
  input  wire ctp_pkg::ctp_ctrl_s  ctrl,
  input  wire logic [7:0]          duty_low,
  input  wire logic                wr_high,
  input  wire logic [7:0]          wr_byte,
  // time bases
  input  wire ctp_pkg::ctp_tb_s    tb,
  input  wire ctp_pkg::ctp_t1_s    t1,
  // results
  output logic                     pin,
  output logic                     match,
  output logic                     special,
  output logic                     pwm_mode,
  output logic [7:0]               data_high
);
  logic              off;
  logic              cmp_mode;
  logic [1:0]        lat;
  logic [DUTY_W-1:0] next_duty;
  logic [DUTY_W-1:0] active_duty;

  assign off = (ctrl.mode == ctp_pkg::MODE_OFF);
  assign pwm_mode = (ctrl.mode[3:2] == ctp_pkg::MODE_PWM_TOP);
  assign cmp_mode = (ctrl.mode[3:2] == ctp_pkg::MODE_CMP_TOP);
  assign next_duty   = {duty_low, ctrl.dc_lsb};
  assign active_duty = {data_high, lat};

  assign match = cmp_mode && t1.running && (t1.count == {data_high, duty_low});
  assign special = match && (ctrl.mode == ctp_pkg::MODE_SPECIAL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_high <= '0;
    end else if (ce) begin
      // duty taken only at period end
      if (pwm_mode && tb.period_event) begin
        data_high <= duty_low;
      end else if (!pwm_mode && wr_high) begin
        data_high <= wr_byte;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat <= '0;
    end else if (ce) begin
      if (off) begin
        lat <= '0;
      end else if (pwm_mode && tb.period_event) begin
        lat <= ctrl.dc_lsb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin <= 1'b0;
    end else if (ce) begin
      if (off) begin
        pin <= 1'b0;
      end else if (pwm_mode) begin
        // set at period end unless zero
        if (tb.period_event) begin
          pin <= (next_duty != '0);
        end else if (active_duty == tb.count_ext) begin
          pin <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_duty_clear: assert property (ce && pwm_mode && !tb.period_event && active_duty == tb.count_ext |=> !pin)
    else $error("pin not cleared on duty match");
  a_zero_duty: assert property (ce && pwm_mode && tb.period_event && next_duty == '0 |=> !pin)
    else $error("pin set with zero duty");
endmodule

// ### verification/ctp_far_model.sv
// far-side model: converter counting start pulses, and the output pads
`timescale 1ns/1ps
module ctp_far_model (
  // clock
  input  wire logic       aclk,
  // converter
  input  wire logic       enable_conv,
  input  wire logic       adc_start,
  output logic            adc_enabled,
  output int              starts,
  // output pins
  input  wire logic [1:0] unit_pin,
  output logic [1:0]      pad
);
  logic [1:0] port_dir;
  initial begin
    adc_enabled = 1'b0;
    starts = 0;
    port_dir = 2'b00;
  end
  // every pulse counts, so a start while disabled is seen
  always @(posedge aclk) begin
    adc_enabled <= enable_conv;
    if (adc_start)
      starts <= starts + 1;
  end
  // direction bits cleared
  // an input-direction pad floats to its pull-up
  assign pad = unit_pin | port_dir;
endmodule

// ### verification/tb_top.sv
// bench: register-level tests of the compare-trigger and pwm block
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn, ce, en_conv;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic        awready, wready, bvalid, arready, rvalid, adc_enabled, adc_start;
  logic [1:0]  bresp, rresp, unit_pin, pad;
  int          miscompares, check_count, cycles, starts, hi, per, lows;
  localparam logic [7:0] TB2_CTL [4] = '{8'h04, 8'h05, 8'h06, 8'h7C};
  localparam int         FACT    [4] = '{1, 4, 16, 1};
  localparam logic [1:0] OK = ctp_pkg::RESP_OKAY;

  ctp_top dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .adc_enabled(adc_enabled), .adc_start(adc_start), .unit_pin(unit_pin)
  );
  ctp_far_model far_u (
    .aclk(aclk), .enable_conv(en_conv), .adc_start(adc_start), .adc_enabled(adc_enabled),
    .starts(starts), .unit_pin(unit_pin), .pad(pad)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic ta, tr;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready; tr = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    chk(32'(r), 32'(er));
  endtask

  // one full pwm period from a rising edge of pad 0
  task automatic meas();
    logic prev;
    do @(negedge aclk); while (pad[0] !== 1'b0);
    do @(negedge aclk); while (pad[0] !== 1'b1);
    hi = 1; per = 1; prev = 1'b1;
    forever begin
      @(negedge aclk);
      if (pad[0] === 1'b1 && !prev) break;
      per++;
      if (pad[0] === 1'b1) hi++;
      prev = pad[0];
    end
  endtask

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    aresetn = 1'b0; ce = 1'b1; en_conv = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    miscompares = 0; check_count = 0; cycles = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ctp_pkg::OFS_CTRL[0], v, OK);
    chk(v, 32'h0);
    rd(8'h30, v, ctp_pkg::RESP_SLVERR);
    wr(8'h30, 32'h1, ctp_pkg::RESP_SLVERR);
    $display("test registers done");
    // compare code 1000 leaves the timer running past the match
    wr(ctp_pkg::OFS_LOW[1], 32'h20, OK);
    wr(ctp_pkg::OFS_HIGH[1], 32'h00, OK);
    wr(ctp_pkg::OFS_CTRL[1], 32'h08, OK);
    wr(ctp_pkg::OFS_TB1_CTRL, 32'h01, OK);
    repeat (100) @(posedge aclk);
    rd(ctp_pkg::OFS_TB1_COUNT, v, OK);
    chk(32'(v > 32'h20), 32'h1);
    wr(ctp_pkg::OFS_STATUS, 32'h07, OK);
    wr(ctp_pkg::OFS_CTRL[1], 32'h0B, OK);
    wr(ctp_pkg::OFS_TB1_COUNT, 32'h0, OK);
    repeat (100) @(posedge aclk);
    rd(ctp_pkg::OFS_TB1_COUNT, v, OK);
    chk(32'(v <= 32'h20), 32'h1);
    rd(ctp_pkg::OFS_STATUS, v, OK);
    chk(v & 32'h2, 32'h2);
    chk(32'(starts), 32'h0);
    en_conv <= 1'b1;
    repeat (100) @(posedge aclk);
    chk(32'(starts > 0), 32'h1);
    wr(ctp_pkg::OFS_CTRL[1], 32'h00, OK);
    $display("test trigger done");
    // duty 6 from low byte 1 and lsbs 2, period register 3
    wr(ctp_pkg::OFS_PERIOD, 32'h03, OK);
    wr(ctp_pkg::OFS_LOW[0], 32'h01, OK);
    wr(ctp_pkg::OFS_CTRL[0], 32'h2C, OK);
    for (int i = 0; i < 4; i++) begin
      wr(ctp_pkg::OFS_TB2_CTRL, 32'(TB2_CTL[i]), OK);
      meas();
      meas();
      chk(32'(per), 32'(16 * FACT[i]));
      chk(32'(hi), 32'(6 * FACT[i]));
    end
    $display("test pwm period done");
    wr(ctp_pkg::OFS_HIGH[0], 32'hAA, OK);
    rd(ctp_pkg::OFS_HIGH[0], v, OK);
    chk(v, 32'h01);
    // duty above the period never clears the pin
    wr(ctp_pkg::OFS_LOW[0], 32'hFF, OK);
    repeat (40) @(posedge aclk);
    lows = 0;
    repeat (64) begin
      @(negedge aclk);
      if (pad[0] !== 1'b1) lows++;
    end
    chk(32'(lows), 32'h0);
    wr(ctp_pkg::OFS_CTRL[0], 32'h00, OK);
    repeat (2) @(posedge aclk);
    chk(32'(unit_pin[0]), 32'h0);
    $display("test pwm duty done");
    stop_test();
  end
endmodule
